// [splf_consts.vh]
// Constants for the secure payload limit framer: register map, field
// positions, reset values, payload figures and frame codes.
// Assumes it is included by bare name from the framer module only.
`ifndef SPLF_CONSTS_VH
`define SPLF_CONSTS_VH

// Register byte offsets
`define SPLF_ADDR_CTRL      8'h00
`define SPLF_ADDR_STATUS    8'h04
`define SPLF_ADDR_MASK      8'h08
`define SPLF_ADDR_LIMIT     8'h0C
`define SPLF_ADDR_KEY0      8'h10
`define SPLF_ADDR_KEY1      8'h14
`define SPLF_ADDR_KEY2      8'h18
`define SPLF_ADDR_KEY3      8'h1C

// Control register fields
`define SPLF_CTRL_CIPHER    0
`define SPLF_CTRL_COMPAT    1
`define SPLF_CTRL_MM_LO     2
`define SPLF_CTRL_MM_HI     3
`define SPLF_CTRL_API       4
`define SPLF_CTRL_LSRC      5
`define SPLF_CTRL_LDST      6
`define SPLF_CTRL_RR_LO     8
`define SPLF_CTRL_RR_HI     10
`define SPLF_CTRL_WIDTH     11
`define SPLF_CTRL_RST       11'h010

// Status and mask bits
`define SPLF_EV_REJECT      0
`define SPLF_EV_RXDROP      1
`define SPLF_EV_RXOK        2
`define SPLF_EV_CUT         3
`define SPLF_EV_WIDTH       4

// Payload figures in bytes
`define SPLF_LIM_BASE       8'h74
`define SPLF_LIM_COMPAT     8'h64
`define SPLF_LIM_COMPAT_ENC 8'h5F
`define SPLF_COST_HDR       8'h02
`define SPLF_COST_HDR_ENC   8'h04
`define SPLF_COST_ADDR      8'h06
`define SPLF_COST_ENC       8'h05

// Frame codes and levels
`define SPLF_FT_TX_STATUS   8'h89
`define SPLF_ST_TOO_LARGE   8'h4A
`define SPLF_FT_RX_LONG     8'h80
`define SPLF_FT_RX_SHORT    8'h81
`define SPLF_SEC_NONE       3'h0
`define SPLF_SEC_ENC        3'h4

// Transmit queue depth in packets
`define SPLF_QUEUE_DEPTH    3'h4

`endif

// [splf_framer.v]
// Payload limit framer: configuration registers, limit computation,
// transmit admission and queue control, receive frame typing, stream cuts.
// Assumes request, radio and stream inputs come from logic on clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "splf_consts.vh"

module splf_framer (
  input  wire         clk_i,           // System clock, 125 MHz
  input  wire         rst_i,           // Synchronous reset, active high
  // Wishbone classic slave
  input  wire         wb_cyc_i,        // Bus cycle
  input  wire         wb_stb_i,        // Strobe
  input  wire         wb_we_i,         // Write enable
  input  wire [7:0]   wb_adr_i,        // Byte address
  input  wire [3:0]   wb_sel_i,        // Byte selects
  input  wire [31:0]  wb_dat_i,        // Write data
  output reg  [31:0]  wb_dat_o,        // Read data
  output reg          wb_ack_o,        // Acknowledge
  // API transmit request from host side
  input  wire         tx_req_i,        // Request pulse
  input  wire [7:0]   tx_len_i,        // Payload length in bytes
  input  wire         tx_long_dst_i,   // Destination is long address
  output reg          tx_accept_o,     // Request accepted, pulse
  output reg          tx_reject_o,     // Status frame issued, pulse
  output reg  [7:0]   tx_stat_type_o,  // Status frame type
  output reg  [7:0]   tx_stat_code_o,  // Status code
  output reg          tx_busy_o,       // New requests must wait
  // Radio transmit completion
  input  wire         tx_done_i,       // One packet finished, pulse
  output reg          queue_en_o,      // Parallel queue active
  // Radio receive
  input  wire         rx_valid_i,      // Packet received, pulse
  input  wire         rx_cipher_i,     // Sender cipher flag
  input  wire         rx_hdr_i,        // App header present
  input  wire         rx_long_src_i,   // Over-air source is long
  input  wire         rx_hdr_short_i,  // Header holds short sender
  output reg          rx_out_o,        // Deliver to host, pulse
  output reg  [7:0]   rx_frame_type_o, // API frame type
  // Transparent stream
  input  wire         ser_byte_i,      // One serial byte, pulse
  input  wire         ser_idle_i,      // Stream gap, flush packet
  output reg          pkt_cut_o,       // Close packet, pulse
  // Configuration out
  output reg  [2:0]   sec_level_o,     // Security level
  output reg  [127:0] cipher_key_o,    // Key for the cipher core
  output reg  [7:0]   payload_limit_o, // Current limit, stream dest
  output reg          irq_o            // Level interrupt
);

  reg  [`SPLF_CTRL_WIDTH-1:0] ctrl_r;   // Control register
  reg  [`SPLF_EV_WIDTH-1:0]   status_r; // Sticky events
  reg  [`SPLF_EV_WIDTH-1:0]   mask_r;   // Interrupt mask
  reg  [31:0]                 key_r [0:3]; // Key words
  reg  [2:0]                  inflight_r;  // Packets in flight
  reg  [7:0]                  ser_cnt_r;   // Bytes in open packet

  wire       cipher_enable        = ctrl_r[`SPLF_CTRL_CIPHER];
  wire       legacy_compat_option = ctrl_r[`SPLF_CTRL_COMPAT];
  wire [1:0] mac_mode_setting     = ctrl_r[`SPLF_CTRL_MM_HI:`SPLF_CTRL_MM_LO];
  wire       api_mode             = ctrl_r[`SPLF_CTRL_API];
  wire       own_long_src         = ctrl_r[`SPLF_CTRL_LSRC];
  wire       dst_long_cfg         = ctrl_r[`SPLF_CTRL_LDST];

  // App header only in modes 0 and 3
  wire hdr_on = (mac_mode_setting == 2'h0) || (mac_mode_setting == 2'h3);

  // Limit arithmetic overview:
  // The limit starts at the base figure and loses bytes for each feature
  // that grows the over-air header. The reductions are independent of one
  // another, so they are applied one after the other in a fixed order.
  // Encryption touches three of them: the larger app header, the forced
  // long source address and its own fixed overhead. The compatibility bit
  // overrides the whole chain, so it is applied last and simply replaces
  // whatever the chain produced. The smallest possible result is well
  // above zero, so the subtractions never wrap in eight bits.
  //
  // Payload limit for a given destination form
  function [7:0] limit_f;
    input enc;
    input compat;
    input hdr;
    input lsrc;
    input ldst;
    reg [7:0] lim;
    begin
      lim = `SPLF_LIM_BASE;
      if (hdr) begin
        lim = lim - (enc ? `SPLF_COST_HDR_ENC : `SPLF_COST_HDR);
      end
      if (lsrc || enc) begin
        lim = lim - `SPLF_COST_ADDR;
      end
      if (ldst) begin
        lim = lim - `SPLF_COST_ADDR;
      end
      if (enc) begin
        lim = lim - `SPLF_COST_ENC;
      end
      if (compat) begin
        lim = enc ? `SPLF_LIM_COMPAT_ENC : `SPLF_LIM_COMPAT;
      end
      limit_f = lim;
    end
  endfunction

  // Two copies of the limit are kept:
  // - req_limit follows the destination form of the request on the port,
  //   so each API request is judged against its own addressing.
  // - cfg_limit follows the stored destination bit and feeds the stream
  //   cutter, the limit register and the limit output.
  // Both are purely combinational, so a configuration write affects the
  // very next request without any settling delay. The price is a longer
  // path from the control register into the admission compare.
  //
  // Limits from live configuration, no pipeline stage
  wire [7:0] req_limit = limit_f(cipher_enable, legacy_compat_option, hdr_on,
                                 own_long_src, tx_long_dst_i);
  wire [7:0] cfg_limit = limit_f(cipher_enable, legacy_compat_option, hdr_on,
                                 own_long_src, dst_long_cfg);

  // Queue control:
  // The in-flight count rises on each accepted request and falls on each
  // completion from the radio. Under compatibility mode the cap is one,
  // so the next packet waits until the radio reports the previous one.
  // Requests that arrive while the queue is full get no answer unless too_big rejects them;
  // the host has to watch the busy output before it sends.
  //
  // One in flight under compat, else queue depth
  wire [2:0] cap = legacy_compat_option ? 3'h1 : `SPLF_QUEUE_DEPTH;
  wire       full = (inflight_r >= cap);

  // Request admission outcome
  wire too_big = tx_req_i && api_mode && (tx_len_i > req_limit);
  wire accept  = tx_req_i && !too_big && !full;

  // Receive path:
  // A packet whose cipher flag differs from the local setting is never
  // handed to the host; it only raises the drop event. The frame type
  // depends on how the sender's address is known:
  // - plain packets use the over-air source form directly,
  // - encrypted packets with the app header use the short sender address
  //   that travels inside the header,
  // - encrypted packets without the header always count as long.
  //
  // Receive decisions
  wire rx_match = (rx_cipher_i == cipher_enable);
  wire rx_deliver = rx_valid_i && rx_match;
  wire rx_drop    = rx_valid_i && !rx_match;

  // Source form seen by the API output
  reg  src_short;
  always @* begin
    if (rx_cipher_i && !rx_hdr_i) begin
      src_short = 1'b0;
    end else if (rx_cipher_i) begin
      src_short = rx_hdr_short_i;
    end else begin
      src_short = !rx_long_src_i;
    end
  end

  // Stream cutting:
  // In transparent mode the serial bytes are counted into an open packet.
  // The packet is closed on the byte that brings the count to the limit,
  // or when the stream goes idle with bytes pending. The counter clears
  // in the same cycle as the cut, so the next byte starts a new packet.
  // A limit change in the middle of a packet takes effect at once; a
  // count already past the new limit closes on the very next byte.
  //
  // Transparent stream cut when packet full or stream idle
  wire ser_full = ser_byte_i && !api_mode && (ser_cnt_r + 8'h01 >= cfg_limit);
  wire ser_flush = ser_idle_i && !api_mode && (ser_cnt_r != 8'h00);
  wire cut = ser_full || ser_flush;

  // Events of this cycle
  wire [`SPLF_EV_WIDTH-1:0] ev = {cut, rx_deliver, rx_drop, too_big};

  // Bus handling:
  // A request is taken on the first edge with cycle and strobe high while
  // the acknowledge is still low. The acknowledge follows one cycle later
  // and lasts one cycle, which keeps a held request from being taken twice.
  // Control and key words honour all four byte selects; status and mask
  // are narrow and only look at the lowest lane.
  //
  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr  = bus_req && wb_we_i;

  // Write data merged by byte selects
  function [31:0] merge_f;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  sel;
    integer      i;
    begin
      merge_f = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge_f[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] ctrl_wide = {{(32-`SPLF_CTRL_WIDTH){1'b0}}, ctrl_r};
  wire [31:0] ctrl_wr   = merge_f(ctrl_wide, wb_dat_i, wb_sel_i);

  // Control register and mask
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SPLF_CTRL_RST;
      mask_r <= {`SPLF_EV_WIDTH{1'b0}};
    end else if (bus_wr) begin
      if (wb_adr_i == `SPLF_ADDR_CTRL) begin
        ctrl_r <= ctrl_wr[`SPLF_CTRL_WIDTH-1:0];
      end else if (wb_adr_i == `SPLF_ADDR_MASK) begin
        if (wb_sel_i[0]) begin
          mask_r <= wb_dat_i[`SPLF_EV_WIDTH-1:0];
        end
      end
    end
  end

  // Key storage:
  // The key is written as four words and is never readable over the bus,
  // so software cannot recover it once loaded. The cipher core sees the
  // full key one cycle after the last word lands. A key written in
  // pieces is briefly a mix of old and new words; software should load it
  // while no traffic is running.
  //
  // Key words, one per register
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_key
      always @(posedge clk_i) begin
        if (rst_i) begin
          key_r[g] <= 32'h00000000;
        end else if (bus_wr && (wb_adr_i == (`SPLF_ADDR_KEY0 + g*4))) begin
          key_r[g] <= merge_f(key_r[g], wb_dat_i, wb_sel_i);
        end
      end
    end
  endgenerate

  // Event handling:
  // Each event sets its status bit and the bit stays set until software
  // writes a one to it. If an event and a clear meet in one cycle, the
  // event is kept, so no occurrence is lost. The interrupt is the OR of
  // all status bits that the mask lets through, registered once.
  //
  // Sticky status; a new event wins over a write-one clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= {`SPLF_EV_WIDTH{1'b0}};
    end else if (bus_wr && (wb_adr_i == `SPLF_ADDR_STATUS) && wb_sel_i[0]) begin
      status_r <= (status_r & ~wb_dat_i[`SPLF_EV_WIDTH-1:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  // Bus answer one cycle after request; unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == `SPLF_ADDR_CTRL) begin
          wb_dat_o <= ctrl_wide;
        end else if (wb_adr_i == `SPLF_ADDR_STATUS) begin
          wb_dat_o <= {28'h0000000, status_r};
        end else if (wb_adr_i == `SPLF_ADDR_MASK) begin
          wb_dat_o <= {28'h0000000, mask_r};
        end else if (wb_adr_i == `SPLF_ADDR_LIMIT) begin
          // Limit, in-flight count and queue state
          wb_dat_o <= {20'h00000, queue_en_o, inflight_r, cfg_limit};
        end else begin
          wb_dat_o <= 32'h00000000; // Key words read as zero
        end
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Counting hazards:
  // An accept and a completion in the same cycle leave the count as it
  // was. A completion with nothing in flight is ignored, so a stray pulse
  // from the radio cannot wrap the count below zero.
  //
  // In-flight packet count
  always @(posedge clk_i) begin
    if (rst_i) begin
      inflight_r <= 3'h0;
    end else if (accept && !(tx_done_i && inflight_r != 3'h0)) begin
      inflight_r <= inflight_r + 3'h1;
    end else if (!accept && tx_done_i && inflight_r != 3'h0) begin
      inflight_r <= inflight_r - 3'h1;
    end
  end

  // Transparent byte counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      ser_cnt_r <= 8'h00;
    end else if (cut) begin
      ser_cnt_r <= 8'h00;
    end else if (ser_byte_i && !api_mode) begin
      ser_cnt_r <= ser_cnt_r + 8'h01;
    end
  end

  // Output stage:
  // Every output comes straight from a flip-flop, so all answers appear
  // one cycle after the edge that took the request. Pulses last exactly
  // one cycle. The status frame fields and the receive frame type hold
  // their last value until the next event that updates them, so the host
  // may read them at leisure.
  //
  // Registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_accept_o     <= 1'b0;
      tx_reject_o     <= 1'b0;
      tx_stat_type_o  <= 8'h00;
      tx_stat_code_o  <= 8'h00;
      tx_busy_o       <= 1'b0;
      queue_en_o      <= 1'b0;
      rx_out_o        <= 1'b0;
      rx_frame_type_o <= 8'h00;
      pkt_cut_o       <= 1'b0;
      sec_level_o     <= `SPLF_SEC_NONE;
      cipher_key_o    <= 128'h0;
      payload_limit_o <= 8'h00;
      irq_o           <= 1'b0;
    end else begin
      tx_accept_o <= accept;
      tx_reject_o <= too_big;
      if (too_big) begin
        tx_stat_type_o <= `SPLF_FT_TX_STATUS;
        tx_stat_code_o <= `SPLF_ST_TOO_LARGE;
      end
      tx_busy_o  <= full;
      queue_en_o <= !legacy_compat_option;
      rx_out_o   <= rx_deliver;
      if (rx_deliver) begin
        rx_frame_type_o <= src_short ? `SPLF_FT_RX_SHORT : `SPLF_FT_RX_LONG;
      end
      pkt_cut_o   <= cut;
      sec_level_o <= cipher_enable ? `SPLF_SEC_ENC : `SPLF_SEC_NONE;
      cipher_key_o <= {key_r[3], key_r[2], key_r[1], key_r[0]};
      payload_limit_o <= cfg_limit;
      irq_o <= |(status_r & mask_r);
    end
  end

endmodule // splf_framer
`default_nettype wire

// [splf_framer_props.sv]
// Port checker for the payload limit framer.
// Assumes one clock clk_i and a synchronous active-high rst_i.
`timescale 1ns/1ns
`default_nettype none
module splf_framer_props (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, tx_req_i, tx_done_i,
  input wire logic        tx_accept_o, tx_reject_o, queue_en_o, rx_valid_i, rx_cipher_i,
  input wire logic        rx_hdr_i, rx_long_src_i, rx_out_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [7:0]  tx_stat_type_o, tx_stat_code_o, rx_frame_type_o, payload_limit_o,
  input wire logic [2:0]  sec_level_o
);
  // One clock domain, checks muted while in reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer comes one cycle after the request and lasts one cycle
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
  // Read data is zero outside the answer
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data not idle zero");
  property p_stat; tx_reject_o |-> tx_stat_type_o == 8'h89 && tx_stat_code_o == 8'h4A; endproperty
  a_stat: assert property (p_stat) else $error("status frame wrong");
  property p_one; tx_accept_o || tx_reject_o |-> $past(tx_req_i) && !(tx_accept_o && tx_reject_o); endproperty
  a_one: assert property (p_one) else $error("answer without single request");
  property p_sec; sec_level_o == 3'h0 || sec_level_o == 3'h4; endproperty
  a_sec: assert property (p_sec) else $error("illegal security level");
  property p_max; payload_limit_o <= 8'h74; endproperty
  a_max: assert property (p_max) else $error("limit above base");
  property p_cmp; !queue_en_o && !$past(rst_i) && !$past(rst_i, 2) |->
    payload_limit_o == 8'h64 || payload_limit_o == 8'h5F; endproperty
  a_cmp: assert property (p_cmp) else $error("compat limit wrong");
  property p_q1; !queue_en_o && tx_accept_o && !tx_done_i |=> !tx_accept_o; endproperty
  a_q1: assert property (p_q1) else $error("second packet in compat mode");
  property p_rxd; rx_valid_i && (rx_cipher_i != (sec_level_o == 3'h4)) |=> !rx_out_o; endproperty
  a_rxd: assert property (p_rxd) else $error("mismatched data delivered");
  property p_rxl; rx_out_o && !$past(rx_cipher_i) |->
    rx_frame_type_o == ($past(rx_long_src_i) ? 8'h80 : 8'h81); endproperty
  a_rxl: assert property (p_rxl) else $error("plain frame type wrong");
  property p_rxe; rx_out_o && $past(rx_cipher_i) && !$past(rx_hdr_i) |-> rx_frame_type_o == 8'h80; endproperty
  a_rxe: assert property (p_rxe) else $error("headerless frame type wrong");
endmodule // splf_framer_props
bind splf_framer splf_framer_props i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_req_i,
  .tx_done_i, .tx_accept_o, .tx_reject_o, .queue_en_o, .rx_valid_i, .rx_cipher_i, .rx_hdr_i, .rx_long_src_i,
  .rx_out_o, .wb_dat_o, .tx_stat_type_o, .tx_stat_code_o, .rx_frame_type_o, .payload_limit_o, .sec_level_o);
`default_nettype wire

// [splf_host_model.sv]
// Host side model: issues API transmit requests and counts the answers.
// Assumes go_i from the bench, answers from the framer on clk_i.
`timescale 1ns/1ns
`default_nettype none
module splf_host_model (
  input wire logic       clk_i, rst_i, go_i, ldst_i, accept_i, reject_i,
  input wire logic [7:0] len_i,
  output logic           tx_req_o, tx_ldst_o,
  output logic [7:0]     tx_len_o, n_acc_o, n_rej_o
);
  // Request follows go; idle qualifiers flip so stale values never look valid
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_req_o <= 1'b0;
      n_acc_o  <= 8'h0;
      n_rej_o  <= 8'h0;
    end else begin
      tx_req_o  <= go_i;
      tx_len_o  <= go_i ? len_i : ~tx_len_o;
      tx_ldst_o <= go_i ? ldst_i : ~tx_ldst_o;
      n_acc_o   <= n_acc_o + {7'h0, accept_i};
      n_rej_o   <= n_rej_o + {7'h0, reject_i};
    end
  end
endmodule // splf_host_model
`default_nettype wire

// [splf_framer_tb.sv]
// Self-checking bench for the payload limit framer.
// Assumes the bound checker and the host model beside it.
`timescale 1ns/1ns
`default_nettype none
module splf_framer_tb;
  logic         clk_i, rst_i, cyc, stb, we, go, ldst, tdone, rv, rc, rh, rl, rs, sb, si;
  logic [7:0]   adr, len, tx_len, n_acc, n_rej, tx_stat_type_o, tx_stat_code_o, rx_frame_type_o, payload_limit_o;
  logic [3:0]   sel;
  logic [31:0]  dw, rdat, wb_dat_o;
  logic         wb_ack_o, tx_accept_o, tx_reject_o, tx_busy_o, queue_en_o, rx_out_o, pkt_cut_o, irq_o;
  logic         tx_req, tx_ldst;
  logic [2:0]   sec_level_o;
  logic [127:0] cipher_key_o;
  int           fail_count = 0, n_tests = 0, ea = 0, er = 0, ncut = 0, i;
  logic [6:0]   v;
  splf_framer i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o, .wb_ack_o, .tx_req_i(tx_req), .tx_len_i(tx_len),
    .tx_long_dst_i(tx_ldst), .tx_accept_o, .tx_reject_o, .tx_stat_type_o, .tx_stat_code_o, .tx_busy_o,
    .tx_done_i(tdone), .queue_en_o, .rx_valid_i(rv), .rx_cipher_i(rc), .rx_hdr_i(rh), .rx_long_src_i(rl),
    .rx_hdr_short_i(rs), .rx_out_o, .rx_frame_type_o, .ser_byte_i(sb), .ser_idle_i(si), .pkt_cut_o,
    .sec_level_o, .cipher_key_o, .payload_limit_o, .irq_o);
  splf_host_model i_host (.clk_i, .rst_i, .go_i(go), .ldst_i(ldst), .accept_i(tx_accept_o),
    .reject_i(tx_reject_o), .len_i(len), .tx_req_o(tx_req), .tx_ldst_o(tx_ldst), .tx_len_o(tx_len),
    .n_acc_o(n_acc), .n_rej_o(n_rej));
  // Clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Counts closed transparent packets
  always @(posedge clk_i) if (pkt_cut_o === 1'b1) ncut <= ncut + 1;
  task end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [127:0] g, input [127:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Wishbone classic single cycle, held until ack is sampled
  task wb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  task cfg(input [6:0] c);
    wb(1'b1, 8'h00, {25'h0, c});
    cyc_n(2);
  endtask
  task burst(input int n, input [7:0] l, input d);
    @(posedge clk_i);
    {go, len, ldst} <= {1'b1, l, d};
    repeat (n) @(posedge clk_i);
    go <= 1'b0;
  endtask
  task done(input int n);
    repeat (n) begin
      @(posedge clk_i) tdone <= 1'b1;
      @(posedge clk_i) tdone <= 1'b0;
    end
  endtask
  task rx(input c, h, l, s, eo, input [7:0] et);
    @(posedge clk_i);
    {rv, rc, rh, rl, rs} <= {1'b1, c, h, l, s};
    @(posedge clk_i) rv <= 1'b0;
    #1;
    chk(rx_out_o, eo);
    if (eo) chk(rx_frame_type_o, et);
  endtask
  task bytes(input int n);
    @(posedge clk_i) sb <= 1'b1;
    repeat (n) @(posedge clk_i);
    sb <= 1'b0;
  endtask
  // Expected limit from cipher, compat, mode, source and destination bits
  function automatic [7:0] lim(input [6:0] c);
    logic e, h;
    e = c[0];
    h = (c[3:2] == 2'h0) || (c[3:2] == 2'h3);
    if (c[1]) lim = e ? 8'h5F : 8'h64;
    else lim = 8'h74 - (h ? (e ? 8'h4 : 8'h2) : 8'h0) - ((c[5] | e) ? 8'h6 : 8'h0) - (c[6] ? 8'h6 : 8'h0)
      - (e ? 8'h5 : 8'h0);
  endfunction
  // Reset values, unmapped read, key load
  task t_regs;
    wb(1'b0, 8'h00, 32'h0); chk(rdat, 32'h10);
    wb(1'b0, 8'h0C, 32'h0); chk(rdat, 32'h872);
    wb(1'b0, 8'h20, 32'h0); chk(rdat, 32'h0);
    for (i = 0; i < 4; i++) wb(1'b1, 8'(8'h10 + 4 * i), 32'hC0DE0000 + i);
    cyc_n(2);
    chk(cipher_key_o, {32'hC0DE0003, 32'hC0DE0002, 32'hC0DE0001, 32'hC0DE0000});
    wb(1'b0, 8'h10, 32'h0); chk(rdat, 32'h0);
  endtask
  // Every configuration combination in API mode
  task t_lim;
    for (i = 0; i < 64; i++) begin
      v = {i[5:4], 1'b1, i[3:0]};
      cfg(v);
      chk(payload_limit_o, lim(v));
      chk(sec_level_o, v[0] ? 3'h4 : 3'h0);
      chk(queue_en_o, !v[1]);
    end
  endtask
  // Boundary lengths, status frame, interrupt raise, clear and mask
  task t_tx;
    cfg(7'h14);
    wb(1'b1, 8'h08, 32'h1);
    burst(1, 8'h74, 1'b0); burst(1, 8'h75, 1'b0); burst(1, 8'h6F, 1'b1); burst(1, 8'h6E, 1'b1);
    cyc_n(3); ea += 2; er += 2;
    chk(n_acc, ea); chk(n_rej, er);
    chk(tx_stat_type_o, 8'h89); chk(tx_stat_code_o, 8'h4A); chk(irq_o, 1'b1);
    wb(1'b0, 8'h04, 32'h0); chk(rdat, 32'h1);
    wb(1'b1, 8'h04, 32'h1); cyc_n(2); chk(irq_o, 1'b0);
    wb(1'b1, 8'h08, 32'h0); burst(1, 8'hFF, 1'b0); er++;
    cyc_n(3); chk(irq_o, 1'b0); chk(n_rej, er);
    wb(1'b1, 8'h04, 32'h1); done(2);
  endtask
  // Queue depth with compat off, single packet with compat on
  task t_queue;
    burst(5, 8'h0A, 1'b0); cyc_n(3); ea += 4;
    chk(n_acc, ea); chk(tx_busy_o, 1'b1);
    done(4); cyc_n(2); chk(tx_busy_o, 1'b0);
    cfg(7'h16); burst(2, 8'h0A, 1'b0); cyc_n(3); ea++;
    chk(n_acc, ea); chk(tx_busy_o, 1'b1);
    done(1);
  endtask
  // Received frame typing and cipher mismatch drop
  task t_rx;
    cfg(7'h10);
    rx(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h80);
    rx(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h81);
    rx(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    wb(1'b0, 8'h04, 32'h0); chk(rdat, 32'h6);
    cfg(7'h15); rx(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h80);
    cfg(7'h11); rx(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h81);
    rx(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h80);
  endtask
  // Transparent stream: no size refusal, cut at limit and on gap
  task t_stream;
    cfg(7'h02); burst(1, 8'hC8, 1'b0); cyc_n(3); ea++;
    chk(n_acc, ea); done(1);
    bytes(100); cyc_n(2); chk(ncut, 1);
    bytes(3); cyc_n(2); chk(ncut, 1);
    @(posedge clk_i) si <= 1'b1;
    @(posedge clk_i) si <= 1'b0;
    cyc_n(2); chk(ncut, 2);
  endtask
  // Main sequence
  initial begin
    {rst_i, cyc, stb, we, go, ldst, tdone, rv, rc, rh, rl, rs, sb, si} = 14'h2000;
    {adr, len, sel, dw} = 52'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc_n(2); chk(payload_limit_o, 8'h72);
    t_regs; t_lim; t_tx; t_queue; t_rx; t_stream;
    end_of_test;
  end
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule // splf_framer_tb
`default_nettype wire
